//--- core/mxa_modexp.sv
// Modular exponentiation engine, Z = X^Y mod M, digit-serial Montgomery.
// Assumes software loads the memories while idle and keeps off the engine
// while another on-chip master uses it.
//
// Functional notes
// - Runs only with clock gate set, power-down clear
// - Memories self-clear after reset; done flag follows
// - Interrupt enable writable, enabled after reset
// - Computes X^Y mod M via Montgomery products
// - Lengths 32 to 4096 bits, 32-bit digits
// - Inverse word is a 32-bit configuration register
// - Length code is digit count minus one
// - 128-word operand memories, 256-word temporary memory, least digit lowest address
// - Words above configured length are ignored
// - Launch pulse starts exponentiation
// - Completion sets idle and raises interrupt
// - Clear pulse drops pending interrupt
// - Length, exponent, modulus, inverse left unchanged
`timescale 1ns/1ns
module mxa_modexp (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic engine_clock_gate,
  input wire logic engine_power_down,
  input wire logic modexp_launch,
  input wire logic irq_clear,
  input wire logic done_irq_enable_we,
  input wire logic done_irq_enable_wdata,
  input wire logic length_code_we,
  input wire logic [mxa_pkg::LEN_W-1:0] length_code_wdata,
  input wire logic montgomery_inverse_word_we,
  input wire logic [mxa_pkg::DW-1:0] montgomery_inverse_word_wdata,
  input wire mxa_pkg::mxa_ram_req_s ram_req,
  output logic done_irq_enable,
  output logic [mxa_pkg::LEN_W-1:0] length_code,
  output logic [mxa_pkg::DW-1:0] montgomery_inverse_word,
  output logic idle,
  output logic mem_init_done,
  output logic done_irq,
  output logic [mxa_pkg::DW-1:0] ram_rdata,
  output logic ram_rvalid
);

  // ==========================================================
  // Arithmetic helpers
  function automatic logic [63:0] mxa_mac(input logic [31:0] a, input logic [31:0] b,
                                          input logic [31:0] t, input logic [31:0] c);
    mxa_mac = ({32'h0, a} * {32'h0, b}) + {32'h0, t} + {32'h0, c};
  endfunction

  // Result bit 32 is the borrow out
  function automatic logic [32:0] mxa_sub(input logic [31:0] a, input logic [31:0] b,
                                          input logic bin);
    mxa_sub = {1'b0, a} - {1'b0, b} - {32'h0, bin};
  endfunction

  // ==========================================================
  // Declarations
  logic rst;
  mxa_pkg::mxa_state_e st_r, st_nxt;
  mxa_pkg::mxa_phase_e ph_r, ph_nxt;
  logic [7:0] j_r, j_nxt;
  logic [6:0] i_r, i_nxt;
  logic [mxa_pkg::BIT_W-1:0] bit_r, bit_nxt;
  logic [31:0] bi_r, bi_nxt, m_r, m_nxt, c_r, c_nxt;
  logic bw_r, bw_nxt, ge_r, ge_nxt, idle_r, idle_nxt, init_r, init_nxt;
  logic en_r, en_nxt, pend_r, pend_nxt, irq_r, irq_nxt;
  logic [mxa_pkg::LEN_W-1:0] len_r, len_nxt;
  logic [31:0] mpr_r, mpr_nxt, rdat_r, rdat_nxt;
  logic rvld_r, rvld_nxt, rq_d_r, rq_d_nxt;
  logic [1:0] sel_d_r, sel_d_nxt;
  logic [7:0] ram_addr [mxa_pkg::NUM_RAM];
  logic [31:0] ram_wd [mxa_pkg::NUM_RAM];
  logic ram_we [mxa_pkg::NUM_RAM];
  logic [31:0] ram_rd [mxa_pkg::NUM_RAM];
  logic [2:0] asrc, bsrc, dst;
  logic b_one, in_len, done_evt;
  logic [7:0] lenx;
  logic [31:0] a_wd, m_wd;
  logic [63:0] mac1, mac2, mprod;
  logic [32:0] dif;

  assign rst = !resetn || !engine_clock_gate || engine_power_down;

  // ==========================================================
  // Operand memories
  for (genvar k = 0; k < mxa_pkg::NUM_RAM; k++) begin : g_ram
    localparam int AW = (k == 4) ? mxa_pkg::TMP_AW : mxa_pkg::OPR_AW;
    mxa_ram #(.AW(AW)) u_ram (
      .clk_sys(clk_sys),
      .ce(ce),
      .addr(ram_addr[k][AW-1:0]),
      .wdata(ram_wd[k]),
      .we(ram_we[k]),
      .rdata(ram_rd[k])
    );
  end

  // ==========================================================
  // Operand routing per phase
  always_comb begin
    lenx = {1'b0, len_r};
    in_len = j_r <= lenx;
    asrc = (ph_r == mxa_pkg::PH_TOMX) ? mxa_pkg::RAM_X : mxa_pkg::RAM_Z;
    dst = (ph_r == mxa_pkg::PH_TOMX) ? mxa_pkg::RAM_X : mxa_pkg::RAM_Z;
    bsrc = (ph_r == mxa_pkg::PH_MUL) ? mxa_pkg::RAM_X : mxa_pkg::RAM_Z;
    b_one = (ph_r == mxa_pkg::PH_ONE) || (ph_r == mxa_pkg::PH_OUT);
    a_wd = in_len ? ram_rd[asrc] : 32'h0;
    m_wd = in_len ? ram_rd[mxa_pkg::RAM_M] : 32'h0;
    mac1 = mxa_mac(a_wd, bi_r, ram_rd[mxa_pkg::RAM_T], c_r);
    mac2 = mxa_mac(m_r, m_wd, ram_rd[mxa_pkg::RAM_T], c_r);
    mprod = mxa_mac(ram_rd[mxa_pkg::RAM_T], mpr_r, 32'h0, 32'h0);
    dif = mxa_sub(ram_rd[mxa_pkg::RAM_T], m_wd, bw_r);
  end

  // Memory port steering; the host reaches memories only while idle
  always_comb begin
    for (int k = 0; k < mxa_pkg::NUM_RAM; k++) begin
      ram_addr[k] = j_r;
      ram_wd[k] = 32'h0;
      ram_we[k] = 1'b0;
    end
    case (st_r)
      mxa_pkg::ST_INIT: begin
        for (int k = 0; k < mxa_pkg::NUM_RAM; k++) begin
          ram_we[k] = 1'b1;
        end
      end
      mxa_pkg::ST_IDLE: begin
        ram_addr[ram_req.sel] = {1'b0, ram_req.addr};
        ram_wd[ram_req.sel] = ram_req.wdata;
        ram_we[ram_req.sel] = ram_req.we;
      end
      mxa_pkg::ST_CLR: ram_we[mxa_pkg::RAM_T] = 1'b1;
      mxa_pkg::ST_B_RD: ram_addr[bsrc] = {1'b0, i_r};
      mxa_pkg::ST_P1_WR: begin
        ram_we[mxa_pkg::RAM_T] = 1'b1;
        ram_wd[mxa_pkg::RAM_T] = mac1[31:0];
      end
      mxa_pkg::ST_M_RD: ram_addr[mxa_pkg::RAM_T] = 8'h00;
      mxa_pkg::ST_P2_WR: begin
        ram_addr[mxa_pkg::RAM_T] = j_r - 8'h01;
        ram_we[mxa_pkg::RAM_T] = j_r != 8'h00;
        ram_wd[mxa_pkg::RAM_T] = mac2[31:0];
      end
      mxa_pkg::ST_P2_TOP: begin
        ram_addr[mxa_pkg::RAM_T] = lenx + mxa_pkg::TMP_EXTRA;
        ram_we[mxa_pkg::RAM_T] = 1'b1;
        ram_wd[mxa_pkg::RAM_T] = c_r;
      end
      mxa_pkg::ST_CPY_WR: begin
        ram_we[dst] = 1'b1;
        ram_wd[dst] = ge_r ? dif[31:0] : ram_rd[mxa_pkg::RAM_T];
      end
      mxa_pkg::ST_EXP_RD: ram_addr[mxa_pkg::RAM_Y] = {1'b0, bit_r[11:5]};
      default: ;
    endcase
  end

  // ==========================================================
  // Sequencer
  always_comb begin
    st_nxt = st_r;
    ph_nxt = ph_r;
    j_nxt = j_r;
    i_nxt = i_r;
    bit_nxt = bit_r;
    bi_nxt = bi_r;
    m_nxt = m_r;
    c_nxt = c_r;
    bw_nxt = bw_r;
    ge_nxt = ge_r;
    init_nxt = init_r;
    done_evt = 1'b0;
    case (st_r)
      mxa_pkg::ST_INIT: begin
        j_nxt = j_r + 8'h01;
        if (j_r == mxa_pkg::INIT_LAST) begin
          st_nxt = mxa_pkg::ST_IDLE;
          init_nxt = 1'b1;
          j_nxt = 8'h00;
        end
      end
      mxa_pkg::ST_IDLE: begin
        if (modexp_launch) begin
          ph_nxt = mxa_pkg::PH_TOMX;
          st_nxt = mxa_pkg::ST_CLR;
          j_nxt = 8'h00;
          i_nxt = 7'h00;
        end
      end
      mxa_pkg::ST_CLR: begin
        j_nxt = j_r + 8'h01;
        if (j_r == lenx + mxa_pkg::TMP_EXTRA) begin
          st_nxt = mxa_pkg::ST_B_RD;
        end
      end
      mxa_pkg::ST_B_RD: st_nxt = mxa_pkg::ST_B_LD;
      mxa_pkg::ST_B_LD: begin
        bi_nxt = b_one ? {31'h0, i_r == 7'h00} : ram_rd[bsrc];
        j_nxt = 8'h00;
        c_nxt = 32'h0;
        st_nxt = mxa_pkg::ST_P1_RD;
      end
      mxa_pkg::ST_P1_RD: st_nxt = mxa_pkg::ST_P1_WR;
      mxa_pkg::ST_P1_WR: begin
        c_nxt = mac1[63:32];
        j_nxt = j_r + 8'h01;
        st_nxt = mxa_pkg::ST_P1_RD;
        if (j_r == lenx + mxa_pkg::TMP_EXTRA) begin
          st_nxt = mxa_pkg::ST_M_RD;
        end
      end
      mxa_pkg::ST_M_RD: st_nxt = mxa_pkg::ST_M_LD;
      mxa_pkg::ST_M_LD: begin
        m_nxt = mprod[31:0];
        j_nxt = 8'h00;
        c_nxt = 32'h0;
        st_nxt = mxa_pkg::ST_P2_RD;
      end
      mxa_pkg::ST_P2_RD: st_nxt = mxa_pkg::ST_P2_WR;
      mxa_pkg::ST_P2_WR: begin
        c_nxt = mac2[63:32];
        j_nxt = j_r + 8'h01;
        st_nxt = mxa_pkg::ST_P2_RD;
        if (j_r == lenx + mxa_pkg::TMP_EXTRA) begin
          st_nxt = mxa_pkg::ST_P2_TOP;
        end
      end
      mxa_pkg::ST_P2_TOP: begin
        j_nxt = 8'h00;
        i_nxt = i_r + 7'h01;
        bw_nxt = 1'b0;
        st_nxt = (i_r == len_r) ? mxa_pkg::ST_SUB_RD : mxa_pkg::ST_B_RD;
      end
      mxa_pkg::ST_SUB_RD: st_nxt = mxa_pkg::ST_SUB_CK;
      mxa_pkg::ST_SUB_CK: begin
        bw_nxt = dif[32];
        j_nxt = j_r + 8'h01;
        st_nxt = mxa_pkg::ST_SUB_RD;
        if (j_r == lenx + 8'h01) begin
          ge_nxt = !dif[32];
          bw_nxt = 1'b0;
          j_nxt = 8'h00;
          st_nxt = mxa_pkg::ST_CPY_RD;
        end
      end
      mxa_pkg::ST_CPY_RD: st_nxt = mxa_pkg::ST_CPY_WR;
      mxa_pkg::ST_CPY_WR: begin
        bw_nxt = dif[32];
        j_nxt = j_r + 8'h01;
        st_nxt = (j_r == lenx) ? mxa_pkg::ST_NEXT : mxa_pkg::ST_CPY_RD;
      end
      mxa_pkg::ST_NEXT: begin
        j_nxt = 8'h00;
        i_nxt = 7'h00;
        st_nxt = mxa_pkg::ST_CLR;
        case (ph_r)
          mxa_pkg::PH_TOMX: ph_nxt = mxa_pkg::PH_ONE;
          mxa_pkg::PH_ONE: begin
            ph_nxt = mxa_pkg::PH_SQR;
            bit_nxt = {len_r, mxa_pkg::DIGIT_TOP_BIT};
          end
          mxa_pkg::PH_SQR: st_nxt = mxa_pkg::ST_EXP_RD;
          mxa_pkg::PH_MUL: st_nxt = mxa_pkg::ST_ADV;
          default: begin
            st_nxt = mxa_pkg::ST_IDLE;
            done_evt = 1'b1;
          end
        endcase
      end
      mxa_pkg::ST_EXP_RD: st_nxt = mxa_pkg::ST_EXP_BIT;
      mxa_pkg::ST_EXP_BIT: begin
        if (ram_rd[mxa_pkg::RAM_Y][bit_r[4:0]]) begin
          ph_nxt = mxa_pkg::PH_MUL;
          st_nxt = mxa_pkg::ST_CLR;
        end else begin
          st_nxt = mxa_pkg::ST_ADV;
        end
      end
      mxa_pkg::ST_ADV: begin
        st_nxt = mxa_pkg::ST_CLR;
        if (bit_r == 12'h000) begin
          ph_nxt = mxa_pkg::PH_OUT;
        end else begin
          ph_nxt = mxa_pkg::PH_SQR;
          bit_nxt = bit_r - 12'h001;
        end
      end
      default: st_nxt = mxa_pkg::ST_IDLE;
    endcase
    idle_nxt = (st_nxt == mxa_pkg::ST_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= mxa_pkg::ST_INIT;
      ph_r <= mxa_pkg::PH_TOMX;
      j_r <= 8'h00;
      i_r <= 7'h00;
      bit_r <= 12'h000;
      bi_r <= 32'h0;
      m_r <= 32'h0;
      c_r <= 32'h0;
      bw_r <= 1'b0;
      ge_r <= 1'b0;
      idle_r <= 1'b0;
      init_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      ph_r <= ph_nxt;
      j_r <= j_nxt;
      i_r <= i_nxt;
      bit_r <= bit_nxt;
      bi_r <= bi_nxt;
      m_r <= m_nxt;
      c_r <= c_nxt;
      bw_r <= bw_nxt;
      ge_r <= ge_nxt;
      idle_r <= idle_nxt;
      init_r <= init_nxt;
    end
  end

  // ==========================================================
  // Configuration, interrupt and host read path
  // Length and inverse writes while busy are dropped so a run sees stable settings
  always_comb begin
    en_nxt = en_r;
    len_nxt = len_r;
    mpr_nxt = mpr_r;
    if (done_irq_enable_we) begin
      en_nxt = done_irq_enable_wdata;
    end
    if (st_r == mxa_pkg::ST_IDLE && length_code_we) begin
      len_nxt = length_code_wdata;
    end
    if (st_r == mxa_pkg::ST_IDLE && montgomery_inverse_word_we) begin
      mpr_nxt = montgomery_inverse_word_wdata;
    end
    pend_nxt = pend_r;
    if (irq_clear) begin
      pend_nxt = 1'b0;
    end
    if (done_evt) begin
      pend_nxt = 1'b1;
    end
    irq_nxt = pend_nxt && en_nxt;
    rq_d_nxt = (st_r == mxa_pkg::ST_IDLE) && ram_req.re;
    sel_d_nxt = ram_req.sel;
    rvld_nxt = rq_d_r;
    rdat_nxt = rq_d_r ? ram_rd[{1'b0, sel_d_r}] : rdat_r;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      en_r <= mxa_pkg::IRQ_EN_RST;
      len_r <= mxa_pkg::LEN_RST;
      mpr_r <= mxa_pkg::MPRIME_RST;
      pend_r <= 1'b0;
      irq_r <= 1'b0;
      rq_d_r <= 1'b0;
      sel_d_r <= 2'h0;
      rvld_r <= 1'b0;
      rdat_r <= 32'h0;
    end else if (ce) begin
      en_r <= en_nxt;
      len_r <= len_nxt;
      mpr_r <= mpr_nxt;
      pend_r <= pend_nxt;
      irq_r <= irq_nxt;
      rq_d_r <= rq_d_nxt;
      sel_d_r <= sel_d_nxt;
      rvld_r <= rvld_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign done_irq_enable = en_r;
  assign length_code = len_r;
  assign montgomery_inverse_word = mpr_r;
  assign idle = idle_r;
  assign mem_init_done = init_r;
  assign done_irq = irq_r;
  assign ram_rdata = rdat_r;
  assign ram_rvalid = rvld_r;

endmodule

//--- inc/mxa_pkg.sv
// Shared constants, types and state codes of the modular exponentiation engine.
// Assumes a single clock domain and plain control ports, no register bus.
package mxa_pkg;

  // ==========================================================
  // Widths and memory layout
  localparam int DW = 32;
  localparam int LEN_W = 7;
  localparam int BIT_W = 12;
  localparam int OPR_AW = 7;
  localparam int TMP_AW = 8;
  localparam int NUM_RAM = 5;

  // Memory index; the host select codes use the first four
  localparam logic [2:0] RAM_M = 3'h0;
  localparam logic [2:0] RAM_Z = 3'h1;
  localparam logic [2:0] RAM_Y = 3'h2;
  localparam logic [2:0] RAM_X = 3'h3;
  localparam logic [2:0] RAM_T = 3'h4;

  // ==========================================================
  // Reset values and counts
  localparam logic IRQ_EN_RST = 1'b1;
  localparam logic [LEN_W-1:0] LEN_RST = 7'h00;
  localparam logic [DW-1:0] MPRIME_RST = 32'h0000_0000;
  localparam logic [7:0] INIT_LAST = 8'hFF;
  localparam logic [7:0] TMP_EXTRA = 8'h02;
  localparam logic [4:0] DIGIT_TOP_BIT = 5'h1F;

  // ==========================================================
  // Sequencer states and exponentiation phases
  typedef enum logic [4:0] {
    ST_INIT    = 5'h00,
    ST_IDLE    = 5'h01,
    ST_CLR     = 5'h02,
    ST_B_RD    = 5'h03,
    ST_B_LD    = 5'h04,
    ST_P1_RD   = 5'h05,
    ST_P1_WR   = 5'h06,
    ST_M_RD    = 5'h07,
    ST_M_LD    = 5'h08,
    ST_P2_RD   = 5'h09,
    ST_P2_WR   = 5'h0A,
    ST_P2_TOP  = 5'h0B,
    ST_SUB_RD  = 5'h0C,
    ST_SUB_CK  = 5'h0D,
    ST_CPY_RD  = 5'h0E,
    ST_CPY_WR  = 5'h0F,
    ST_NEXT    = 5'h10,
    ST_EXP_RD  = 5'h11,
    ST_EXP_BIT = 5'h12,
    ST_ADV     = 5'h13
  } mxa_state_e;

  typedef enum logic [2:0] {
    PH_TOMX = 3'h0,
    PH_ONE  = 3'h1,
    PH_SQR  = 3'h2,
    PH_MUL  = 3'h3,
    PH_OUT  = 3'h4
  } mxa_phase_e;

  // Host access to the operand memories
  typedef struct packed {
    logic [1:0] sel;
    logic [OPR_AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic we;
    logic re;
  } mxa_ram_req_s;

endpackage

//--- core/mxa_ram.sv
// Single-port word memory with registered read data.
// Assumes one access per cycle; contents are not reset.
`timescale 1ns/1ns
module mxa_ram #(
  parameter int AW = 7
) (
  input wire logic clk_sys,
  input wire logic ce,
  input wire logic [AW-1:0] addr,
  input wire logic [mxa_pkg::DW-1:0] wdata,
  input wire logic we,
  output logic [mxa_pkg::DW-1:0] rdata
);

  logic [mxa_pkg::DW-1:0] mem [2**AW];

  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end

endmodule

//--- test/mxa_modexp_checker.sv
// Port-level assertions for the modular exponentiation engine.
// Assumes one clock, synchronous active-low reset; bound at the foot.
`timescale 1ns/1ns
module mxa_modexp_checker (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  input wire logic engine_clock_gate,
  input wire logic engine_power_down,
  input wire logic modexp_launch,
  input wire logic irq_clear,
  input wire logic done_irq_enable_we,
  input wire logic done_irq_enable_wdata,
  input wire logic length_code_we,
  input wire logic [mxa_pkg::LEN_W-1:0] length_code_wdata,
  input wire mxa_pkg::mxa_ram_req_s ram_req,
  input wire logic done_irq_enable,
  input wire logic [mxa_pkg::LEN_W-1:0] length_code,
  input wire logic [mxa_pkg::DW-1:0] montgomery_inverse_word,
  input wire logic idle,
  input wire logic mem_init_done,
  input wire logic done_irq,
  input wire logic ram_rvalid
);
  // ==========================================================
  // Helpers
  // Bound sized for the short operands the bench uses
  localparam logic [15:0] BUSY_MAX = 16'h7530;
  logic run_ok;
  logic [15:0] busy_cnt_r;
  logic [15:0] busy_cnt_nxt;
  assign run_ok = resetn && engine_clock_gate && !engine_power_down;
  always_comb begin
    busy_cnt_nxt = 16'h0000;
    if (run_ok && mem_init_done && !idle) begin
      busy_cnt_nxt = busy_cnt_r + 16'h0001;
    end
  end
  always_ff @(posedge clk_sys) begin
    busy_cnt_r <= busy_cnt_nxt;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // Properties
  property p_gate_reset;
    (!engine_clock_gate || engine_power_down)
      |=> !idle && !mem_init_done && !done_irq && done_irq_enable;
  endproperty
  a_gate_reset: assert property (p_gate_reset) else $error("gated reset not applied");
  property p_init_time;
    $rose(run_ok) |-> !mem_init_done [*8] ##[1:600] mem_init_done;
  endproperty
  a_init_time: assert property (p_init_time) else $error("memory init timing wrong");
  property p_idle_init;
    idle |-> mem_init_done;
  endproperty
  a_idle_init: assert property (p_idle_init) else $error("idle before init done");
  property p_launch;
    modexp_launch && idle && ce && run_ok |=> !idle;
  endproperty
  a_launch: assert property (p_launch) else $error("launch did not start engine");
  property p_busy_max;
    busy_cnt_r < BUSY_MAX;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("engine never finished");
  property p_done_set;
    $rose(idle) && $past(mem_init_done) |-> done_irq == done_irq_enable;
  endproperty
  a_done_set: assert property (p_done_set) else $error("completion irq wrong");
  property p_mask;
    !done_irq_enable |-> !done_irq;
  endproperty
  a_mask: assert property (p_mask) else $error("irq while disabled");
  property p_en_write;
    done_irq_enable_we && ce && run_ok |=> done_irq_enable == $past(done_irq_enable_wdata);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable write lost");
  property p_clear;
    irq_clear && idle && ce && run_ok |=> !done_irq;
  endproperty
  a_clear: assert property (p_clear) else $error("irq not cleared");
  property p_len_wr;
    length_code_we && idle && ce && run_ok |=> length_code == $past(length_code_wdata);
  endproperty
  a_len_wr: assert property (p_len_wr) else $error("length write lost");
  property p_cfg_hold;
    !idle && mem_init_done && run_ok
      |=> $stable(length_code) && $stable(montgomery_inverse_word);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed during run");
  property p_rd;
    ram_req.re && idle && ce && run_ok |-> ##2 ram_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer missing");

  c_done: cover property ($rose(idle) && done_irq);
  c_read: cover property (ram_rvalid);
  c_clear: cover property ($fell(done_irq));
endmodule

bind mxa_modexp mxa_modexp_checker chk_u (.clk_sys, .resetn, .ce, .engine_clock_gate,
  .engine_power_down, .modexp_launch, .irq_clear, .done_irq_enable_we,
  .done_irq_enable_wdata, .length_code_we, .length_code_wdata, .ram_req, .done_irq_enable,
  .length_code, .montgomery_inverse_word, .idle, .mem_init_done, .done_irq, .ram_rvalid);

//--- test/test_modexp_accelerator.sv
// Self-checking bench for the modular exponentiation engine.
// Assumes engine and checker compiled first; ports driven directly.
`timescale 1ns/1ns
module test_modexp_accelerator;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic engine_clock_gate = 1'b1;
  logic engine_power_down = 1'b0;
  logic modexp_launch = 1'b0;
  logic irq_clear = 1'b0;
  logic done_irq_enable_we = 1'b0;
  logic done_irq_enable_wdata = 1'b0;
  logic length_code_we = 1'b0;
  logic [mxa_pkg::LEN_W-1:0] length_code_wdata = 7'h00;
  logic montgomery_inverse_word_we = 1'b0;
  logic [mxa_pkg::DW-1:0] montgomery_inverse_word_wdata = 32'h0000_0000;
  mxa_pkg::mxa_ram_req_s ram_req = '0;
  logic done_irq_enable;
  logic [mxa_pkg::LEN_W-1:0] length_code;
  logic [mxa_pkg::DW-1:0] montgomery_inverse_word;
  logic idle;
  logic mem_init_done;
  logic done_irq;
  logic [mxa_pkg::DW-1:0] ram_rdata;
  logic ram_rvalid;
  int mismatches = 0;
  int total_checks = 0;

  mxa_modexp dut_u (.clk_sys, .resetn, .ce, .engine_clock_gate, .engine_power_down,
    .modexp_launch, .irq_clear, .done_irq_enable_we, .done_irq_enable_wdata,
    .length_code_we, .length_code_wdata, .montgomery_inverse_word_we,
    .montgomery_inverse_word_wdata, .ram_req, .done_irq_enable, .length_code,
    .montgomery_inverse_word, .idle, .mem_init_done, .done_irq, .ram_rdata, .ram_rvalid);

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Reporting and reference math
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [63:0] ref_exp(input logic [63:0] x, input logic [63:0] y,
                                         input logic [63:0] m, input int bits);
    logic [127:0] r;
    r = 128'h1;
    for (int i = bits - 1; i >= 0; i--) begin
      r = (r * r) % {64'h0, m};
      if (y[i]) r = (r * {64'h0, x}) % {64'h0, m};
    end
    return r[63:0];
  endfunction
  function automatic logic [31:0] ref_mprime(input logic [31:0] m0);
    logic [31:0] inv;
    inv = m0;
    repeat (5) inv = inv * (32'h2 - m0 * inv);
    return 32'h0 - inv;
  endfunction

  // ==========================================================
  // Port access tasks
  task automatic ram_wr(input logic [1:0] s, input int a, input logic [31:0] d);
    @(posedge clk_sys);
    ram_req <= '{sel: s, addr: 7'(a), wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk_sys);
    ram_req.we <= 1'b0;
  endtask
  task automatic ram_rd(input logic [1:0] s, input int a, output logic [31:0] d,
                        output logic ok);
    @(posedge clk_sys);
    ram_req <= '{sel: s, addr: 7'(a), wdata: 32'h0000_0000, we: 1'b0, re: 1'b1};
    @(posedge clk_sys);
    ram_req.re <= 1'b0;
    ok = 1'b0;
    d = 32'h0000_0000;
    repeat (3) begin
      @(negedge clk_sys);
      if (ram_rvalid === 1'b1) begin
        ok = 1'b1;
        d = ram_rdata;
      end
    end
  endtask
  task automatic rd_chk(input logic [1:0] s, input int a, input logic [31:0] exp);
    logic [31:0] d;
    logic ok;
    ram_rd(s, a, d, ok);
    chk_bit(ok, 1'b1, "read answered");
    chk_word(d, exp, "read data");
  endtask
  task automatic ctl(input logic l, input logic c, input logic ew, input logic ev);
    @(posedge clk_sys);
    modexp_launch <= l;
    irq_clear <= c;
    done_irq_enable_we <= ew;
    done_irq_enable_wdata <= ev;
    @(posedge clk_sys);
    modexp_launch <= 1'b0;
    irq_clear <= 1'b0;
    done_irq_enable_we <= 1'b0;
  endtask
  task automatic wait_idle(input int limit);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (idle !== 1'b1) begin
      n++;
      if (n > limit) begin
        mismatches++;
        $display("BAD at %0t: wait for idle ran out", $time);
        end_of_test();
      end
      @(negedge clk_sys);
    end
  endtask

  // ==========================================================
  // One exponentiation of n digits, with junk above the length
  task automatic run_case(input int n, input logic en, input logic [63:0] x,
                          input logic [63:0] y, input logic [63:0] m);
    logic [63:0] z;
    logic [255:0] rb;
    logic [31:0] d;
    logic ok;
    z = ref_exp(x, y, m, 32 * n);
    rb = (256'h1 << (64 * n)) % {192'h0, m};
    ctl(1'b0, 1'b0, 1'b1, en);
    @(posedge clk_sys);
    length_code_we <= 1'b1;
    length_code_wdata <= 7'(n - 1);
    montgomery_inverse_word_we <= 1'b1;
    montgomery_inverse_word_wdata <= ref_mprime(m[31:0]);
    @(posedge clk_sys);
    length_code_we <= 1'b0;
    montgomery_inverse_word_we <= 1'b0;
    for (int i = 0; i < n; i++) begin
      ram_wr(mxa_pkg::RAM_X[1:0], i, x[32*i +: 32]);
      ram_wr(mxa_pkg::RAM_Y[1:0], i, y[32*i +: 32]);
      ram_wr(mxa_pkg::RAM_M[1:0], i, m[32*i +: 32]);
      ram_wr(mxa_pkg::RAM_Z[1:0], i, rb[32*i +: 32]);
    end
    for (int s = 0; s < 4; s++) ram_wr(2'(s), n, 32'hDEAD_BEEF);
    ctl(1'b1, 1'b0, 1'b0, 1'b0);
    @(negedge clk_sys);
    chk_bit(idle, 1'b0, "busy after launch");
    ram_rd(mxa_pkg::RAM_Z[1:0], 0, d, ok);
    chk_bit(ok, 1'b0, "read refused while busy");
    // Config writes and relaunch while busy, taken with ce high, must be dropped
    @(posedge clk_sys);
    modexp_launch <= 1'b1;
    length_code_we <= 1'b1;
    length_code_wdata <= 7'h55;
    montgomery_inverse_word_we <= 1'b1;
    montgomery_inverse_word_wdata <= 32'h0F0F_0F0F;
    @(posedge clk_sys);
    modexp_launch <= 1'b0;
    length_code_we <= 1'b0;
    montgomery_inverse_word_we <= 1'b0;
    ce <= 1'b0;
    repeat (8) @(posedge clk_sys);
    ce <= 1'b1;
    wait_idle(30000);
    chk_bit(done_irq, en, "completion irq");
    chk_word({25'h0, length_code}, 32'(n - 1), "length kept");
    chk_word(montgomery_inverse_word, ref_mprime(m[31:0]), "inverse kept");
    for (int i = 0; i < n; i++) begin
      rd_chk(mxa_pkg::RAM_Z[1:0], i, z[32*i +: 32]);
      rd_chk(mxa_pkg::RAM_Y[1:0], i, y[32*i +: 32]);
      rd_chk(mxa_pkg::RAM_M[1:0], i, m[32*i +: 32]);
    end
    ctl(1'b0, 1'b0, 1'b1, 1'b1);
    @(negedge clk_sys);
    chk_bit(done_irq, 1'b1, "pending shown once enabled");
    ctl(1'b0, 1'b1, 1'b0, 1'b0);
    @(negedge clk_sys);
    chk_bit(done_irq, 1'b0, "irq cleared");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] d;
    logic ok;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_bit(idle, 1'b0, "idle in reset");
    chk_bit(done_irq_enable, mxa_pkg::IRQ_EN_RST, "enable reset");
    chk_word({25'h0, length_code}, 32'h0000_0000, "length reset");
    chk_word(montgomery_inverse_word, mxa_pkg::MPRIME_RST, "inverse reset");
    @(posedge clk_sys);
    resetn <= 1'b1;
    ram_rd(mxa_pkg::RAM_Z[1:0], 5, d, ok);
    chk_bit(ok, 1'b0, "read refused during init");
    chk_bit(mem_init_done, 1'b0, "init running");
    wait_idle(600);
    chk_bit(mem_init_done, 1'b1, "init done");
    rd_chk(mxa_pkg::RAM_Z[1:0], 5, 32'h0000_0000);
    run_case(1, 1'b1, 64'h1234_5678, 64'h8000_0011, 64'hF123_4567);
    run_case(2, 1'b0, 64'h0BAD_CAFE_0000_1111, 64'h8001_0000_0000_0007,
             64'hC3A5_0000_1357_9BDF);
    for (int k = 0; k < 2; k++) begin
      ctl(1'b0, 1'b0, 1'b1, 1'b0);
      @(posedge clk_sys);
      engine_clock_gate <= (k != 0);
      engine_power_down <= (k != 0);
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk_bit(idle, 1'b0, "held in reset");
      chk_bit(mem_init_done, 1'b0, "init restarted");
      chk_bit(done_irq_enable, 1'b1, "enable back to reset");
      @(posedge clk_sys);
      engine_clock_gate <= 1'b1;
      engine_power_down <= 1'b0;
      wait_idle(600);
    end
    end_of_test();
  end
endmodule
